// [rpu_tcm_pkg.sv]
`default_nettype none
package rpu_tcm_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [31:0] LOC_BANK_A = 32'h0000_0000;
  localparam logic [31:0] LOC_BANK_B = 32'h0002_0000;
  localparam logic [31:0] GBL_C0_A = 32'hFFE0_0000;
  localparam logic [31:0] GBL_C0_B = 32'hFFE2_0000;
  localparam logic [31:0] GBL_C0_ICACHE = 32'hFFE4_0000;
  localparam logic [31:0] GBL_C0_DCACHE = 32'hFFE5_0000;
  localparam logic [31:0] GBL_C1_A = 32'hFFE9_0000;
  localparam logic [31:0] GBL_C1_B = 32'hFFEB_0000;
  localparam logic [31:0] GBL_C1_ICACHE = 32'hFFEC_0000;
  localparam logic [31:0] GBL_C1_DCACHE = 32'hFFED_0000;
  // lock-step banks span two 64 KB windows
  localparam logic [31:0] GBL_LS_A_HI = 32'hFFE1_0000;
  localparam logic [31:0] GBL_LS_B_HI = 32'hFFE3_0000;
  localparam int LOC_BANK_BIT = 17;
  localparam int HALF_BIT = 16;
  localparam int WIN_LSB = 16;

  // ****************************************
  // ecc and timing
  // ****************************************
  localparam int DATA_W = 32;
  localparam int CODE_W = 39;
  localparam int HAM_POS = 38;
  localparam int SYN_W = 6;
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [1:0] {SRC_C0, SRC_C1, SRC_GBL, SRC_NONE} src_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic cache_hit;
    logic corrected;
    logic double_err;
    logic [31:0] rdata;
  } resp_t;

  typedef struct packed {
    logic valid;
    src_t src;
    logic err;
    logic cache_hit;
    logic write;
  } stage_t;

  typedef struct packed {
    logic [1:0] sync0;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] settle;
    logic mode_valid;
    logic lockstep;
    logic [1:0] core_rst;
    logic fault;
    stage_t p1;
    resp_t r0;
    resp_t r1;
    resp_t rg;
  } state_t;

endpackage : rpu_tcm_pkg
`default_nettype wire

// [rpu_tcm_map.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - mode changes only under power-on reset; fixed otherwise.
// - lock-step runs both cores as a compared redundant pair.
// - lock-step exposes only one processor interface.
// - clamp and split select inputs choose the configuration.
// - split core zero banks locally at 0x0 and 0x20000.
// - split core zero banks globally at FFE0_0000 and FFE2_0000.
// - core zero cache windows globally at FFE4_0000 and FFE5_0000.
// - split core one banks local 0x0/0x20000, global FFE9_0000/FFEB_0000.
// - split core one cache windows globally at FFEC_0000 and FFED_0000.
// - lock-step first bank is 128KB, local zero, global FFE0_0000.
// - lock-step second bank is 128KB, local 0x20000, global FFE2_0000.
// - global bank accesses succeed only when protection unit allows.
// - every stored word carries generated check bits.
// - reads correct single-bit errors and flag double-bit errors.
// - lock-step core zero reset resets both; split resets independent.
module rpu_tcm_map
  import rpu_tcm_pkg::*;
#(
  parameter int BANK_WORDS = 16384
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic resetn,
  // mode select pins
  input wire logic lockstep_clamp_select,
  input wire logic split_mode_select,
  // core reset requests and run signatures
  input wire logic core_zero_rst_req,
  input wire logic core_one_rst_req,
  input wire logic [31:0] core_zero_sig,
  input wire logic [31:0] core_one_sig,
  // local and global access ports
  input wire req_t core_zero_req,
  input wire req_t core_one_req,
  input wire req_t gbl_req,
  input wire logic ppu_allow,
  input wire logic [CODE_W-1:0] ecc_inject,
  // answers
  output resp_t core_zero_resp,
  output resp_t core_one_resp,
  output resp_t gbl_resp,
  // status and core control
  output logic mode_valid,
  output logic mode_lockstep,
  output logic [1:0] core_rst,
  output logic lockstep_fault
);

  localparam int AW = $clog2(BANK_WORDS);

  // ****************************************
  // ecc functions
  // ****************************************
  function automatic logic [CODE_W-1:0] ecc_enc(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= HAM_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[j];
        j++;
      end
    end
    for (int k = 0; k < SYN_W; k++) begin
      for (int p = 1; p <= HAM_POS; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          c[(1<<k)-1] = c[(1<<k)-1] ^ c[p-1];
        end
      end
    end
    c[CODE_W-1] = ^c[CODE_W-2:0];
    return c;
  endfunction : ecc_enc
  // returns {double, corrected, data}
  function automatic logic [DATA_W+1:0] ecc_dec(input logic [CODE_W-1:0] c);
    logic [CODE_W-1:0] f;
    logic [SYN_W-1:0] syn;
    logic par;
    logic [DATA_W-1:0] d;
    logic cor, dbl;
    int j;
    f = c;
    syn = '0;
    par = ^c;
    d = '0;
    cor = 1'b0;
    dbl = 1'b0;
    j = 0;
    for (int p = 1; p <= HAM_POS; p++) begin
      if (c[p-1]) begin
        syn = syn ^ SYN_W'(p);
      end
    end
    if (par) begin
      cor = 1'b1;
      if (syn != '0 && int'(syn) <= HAM_POS) begin
        f[int'(syn)-1] = ~f[int'(syn)-1];
      end
    end else if (syn != '0) begin
      dbl = 1'b1;
    end
    for (int p = 1; p <= HAM_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = f[p-1];
        j++;
      end
    end
    return {dbl, cor, d};
  endfunction : ecc_dec
  // ****************************************
  // state and memory
  // ****************************************
  state_t st_reg;
  state_t st_next;
  logic [CODE_W-1:0] mem [4*BANK_WORDS];
  logic [CODE_W-1:0] rd_word_reg;
  src_t grant;
  req_t sel;
  logic hit;
  logic cache;
  logic [1:0] bank;
  logic [AW+1:0] phys;
  logic [DATA_W+1:0] dec;
  logic busy;
  // ****************************************
  // arbitration and address decode
  // ****************************************
  always_comb begin
    busy = st_reg.p1.valid | st_reg.r0.ack | st_reg.r1.ack | st_reg.rg.ack;
    grant = SRC_NONE;
    sel = '0;
    if (st_reg.mode_valid && !busy) begin
      if (core_zero_req.valid) begin
        grant = SRC_C0;
        sel = core_zero_req;
      end else if (core_one_req.valid && !st_reg.lockstep) begin
        grant = SRC_C1;
        sel = core_one_req;
      end else if (gbl_req.valid) begin
        grant = SRC_GBL;
        sel = gbl_req;
      end
    end
    hit = 1'b0;
    cache = 1'b0;
    bank = 2'h0;
    if (grant == SRC_C0 || grant == SRC_C1) begin
      if (sel.addr[31:LOC_BANK_BIT+1] == '0) begin
        bank[0] = sel.addr[LOC_BANK_BIT];
        if (st_reg.lockstep) begin
          hit = 1'b1;
          bank[1] = sel.addr[HALF_BIT];
        end else begin
          hit = ~sel.addr[HALF_BIT];
          bank[1] = (grant == SRC_C1);
        end
      end
    end else if (grant == SRC_GBL) begin
      if (st_reg.lockstep) begin
        case (sel.addr[31:WIN_LSB])
          GBL_C0_A[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h0; end
          GBL_LS_A_HI[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h2; end
          GBL_C0_B[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h1; end
          GBL_LS_B_HI[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h3; end
          GBL_C0_ICACHE[31:WIN_LSB], GBL_C0_DCACHE[31:WIN_LSB]: cache = 1'b1;
          default: hit = 1'b0;
        endcase
      end else begin
        case (sel.addr[31:WIN_LSB])
          GBL_C0_A[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h0; end
          GBL_C0_B[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h1; end
          GBL_C1_A[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h2; end
          GBL_C1_B[31:WIN_LSB]: begin hit = 1'b1; bank = 2'h3; end
          GBL_C0_ICACHE[31:WIN_LSB], GBL_C0_DCACHE[31:WIN_LSB]: cache = 1'b1;
          GBL_C1_ICACHE[31:WIN_LSB], GBL_C1_DCACHE[31:WIN_LSB]: cache = 1'b1;
          default: hit = 1'b0;
        endcase
      end
      if (!ppu_allow) begin
        hit = 1'b0;
      end
    end
    phys = {bank, sel.addr[AW+1:2]};
  end
  always_ff @(posedge mclk) begin
    if (grant != SRC_NONE && hit && sel.write) begin
      mem[phys] <= ecc_enc(sel.wdata) ^ ecc_inject;
    end
    rd_word_reg <= mem[phys];
  end

  // ****************************************
  // mode, resets and answers
  // ****************************************
  always_comb begin
    resp_t r;
    r = '0;
    st_next = st_reg;
    dec = ecc_dec(rd_word_reg);
    st_next.sync0 = {lockstep_clamp_select, split_mode_select};
    st_next.sync1 = st_reg.sync0;
    st_next.sync2 = st_reg.sync1;
    if (!st_reg.mode_valid) begin
      if (st_reg.sync1 == st_reg.sync2) begin
        if (st_reg.settle == SETTLE_CYC) begin
          st_next.mode_valid = 1'b1;
          st_next.lockstep = ~(st_reg.sync2 == 2'h1);
        end else begin
          st_next.settle = st_reg.settle + 2'h1;
        end
      end else begin
        st_next.settle = 2'h0;
      end
      st_next.core_rst = 2'h3;
    end else if (st_reg.lockstep) begin
      st_next.core_rst = {2{core_zero_rst_req}};
      if (st_reg.core_rst == 2'h0 && core_zero_sig != core_one_sig) begin
        st_next.fault = 1'b1;
      end
    end else begin
      st_next.core_rst = {core_one_rst_req, core_zero_rst_req};
    end
    st_next.p1.valid = (grant != SRC_NONE);
    st_next.p1.src = grant;
    st_next.p1.err = ~hit & ~cache;
    st_next.p1.cache_hit = cache;
    st_next.p1.write = sel.write;
    st_next.r0 = '0;
    st_next.r1 = '0;
    st_next.rg = '0;
    if (st_reg.p1.valid) begin
      r.ack = 1'b1;
      r.err = st_reg.p1.err;
      r.cache_hit = st_reg.p1.cache_hit;
      if (!st_reg.p1.err && !st_reg.p1.cache_hit && !st_reg.p1.write) begin
        r.rdata = dec[DATA_W-1:0];
        r.corrected = dec[DATA_W];
        r.double_err = dec[DATA_W+1];
      end
      case (st_reg.p1.src)
        SRC_C0: st_next.r0 = r;
        SRC_C1: st_next.r1 = r;
        SRC_GBL: st_next.rg = r;
        default: st_next.rg = '0;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{p1: '{src: SRC_NONE, default: '0}, core_rst: 2'h3, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign core_zero_resp = st_reg.r0;
  assign core_one_resp = st_reg.r1;
  assign gbl_resp = st_reg.rg;
  assign mode_valid = st_reg.mode_valid;
  assign mode_lockstep = st_reg.lockstep;
  assign core_rst = st_reg.core_rst;
  assign lockstep_fault = st_reg.fault;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence gbl_denied_s; grant == SRC_GBL && !ppu_allow; endsequence
  sequence err_answer_s; gbl_resp.ack && gbl_resp.err; endsequence
  mode_frozen_a: assert property (mode_valid |=> $stable(mode_lockstep) && mode_valid)
    else $error("mode changed after selection");
  hold_reset_a: assert property (!mode_valid |-> core_rst == 2'h3) else $error("cores left reset early");
  ls_reset_a: assert property (mode_valid && mode_lockstep && core_zero_rst_req |=> core_rst == 2'h3)
    else $error("lock-step reset did not reach both cores");
  single_if_a: assert property (mode_lockstep |-> !core_one_resp.ack) else $error("second port answered");
  gate_deny_a: assert property (gbl_denied_s |-> ##2 err_answer_s) else $error("denied access passed");
  split_c1_map_a: assert property (grant == SRC_GBL && ppu_allow && !mode_lockstep
      && gbl_req.addr[31:WIN_LSB] == GBL_C1_B[31:WIN_LSB] |-> hit && bank == 2'h3)
    else $error("core one second bank misdecoded");
  ls_upper_a: assert property (grant == SRC_GBL && ppu_allow && mode_lockstep
      && gbl_req.addr[31:WIN_LSB] == GBL_LS_A_HI[31:WIN_LSB] |-> hit && bank == 2'h2)
    else $error("lock-step first bank upper half misdecoded");
  split_loc_a: assert property (grant == SRC_C0 && !mode_lockstep
      && core_zero_req.addr[31:WIN_LSB] == LOC_BANK_B[31:WIN_LSB] |-> hit && bank == 2'h1)
    else $error("core zero local second bank misdecoded");
  cache_win_a: assert property (grant == SRC_GBL && gbl_req.addr[31:WIN_LSB] == GBL_C0_DCACHE[31:WIN_LSB]
      |-> ##2 gbl_resp.ack && gbl_resp.cache_hit && !gbl_resp.err)
    else $error("cache window not answered");
  ecc_excl_a: assert property (core_zero_resp.double_err |-> !core_zero_resp.corrected)
    else $error("double error reported as corrected");
  ls_fault_a: assert property (mode_lockstep && core_rst == 2'h0
      && core_zero_sig != core_one_sig |=> lockstep_fault)
    else $error("core divergence not flagged");
endmodule : rpu_tcm_map
`default_nettype wire

// [bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// requester standing on one access port
// ****************************************
module bus_master
  import rpu_tcm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // command from bench
  input wire logic go,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  // access port
  output var req_t req_reg,
  input wire resp_t resp,
  // outcome
  output logic done_reg,
  output resp_t got_reg
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_reg <= '0;
      done_reg <= 1'b0;
      got_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (req_reg.valid && resp.ack) begin
        // released lines go inverse, never a stale copy
        req_reg <= '{1'b0, ~req_reg.write, ~req_reg.addr, ~req_reg.wdata};
        got_reg <= resp;
        done_reg <= 1'b1;
      end else if (go && !req_reg.valid) begin
        req_reg <= '{1'b1, wr, addr, wdata};
      end
    end
  end
endmodule : bus_master
`default_nettype wire

// [test_rpu_tcm_map.sv]
`timescale 1ns/1ps
`default_nettype none
module test_rpu_tcm_map
  import rpu_tcm_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic mclk, resetn, clamp, split, rq0, rq1, ppu_allow;
  logic [31:0] sig0, sig1;
  logic [CODE_W-1:0] inj;
  logic go [3];
  logic wr [3];
  logic [31:0] ad [3];
  logic [31:0] wd [3];
  req_t rq [3];
  resp_t rs [3];
  logic dn [3];
  resp_t got [3];
  logic mode_valid, mode_lockstep, fault;
  logic [1:0] core_rst;
  int err_count, checks;

  rpu_tcm_map #(.BANK_WORDS(64)) uut (
    .mclk(mclk), .resetn(resetn), .lockstep_clamp_select(clamp), .split_mode_select(split),
    .core_zero_rst_req(rq0), .core_one_rst_req(rq1), .core_zero_sig(sig0), .core_one_sig(sig1),
    .core_zero_req(rq[0]), .core_one_req(rq[1]), .gbl_req(rq[2]), .ppu_allow(ppu_allow),
    .ecc_inject(inj), .core_zero_resp(rs[0]), .core_one_resp(rs[1]), .gbl_resp(rs[2]),
    .mode_valid(mode_valid), .mode_lockstep(mode_lockstep), .core_rst(core_rst),
    .lockstep_fault(fault)
  );

  for (genvar i = 0; i < 3; i++) begin : g_m
    bus_master m (.mclk(mclk), .resetn(resetn), .go(go[i]), .wr(wr[i]), .addr(ad[i]),
      .wdata(wd[i]), .req_reg(rq[i]), .resp(rs[i]), .done_reg(dn[i]), .got_reg(got[i]));
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic op(input int p, input logic w, input logic [31:0] a, input logic [31:0] d,
                    output resp_t r);
    int n;
    go[p] = 1'b1;
    wr[p] = w;
    ad[p] = a;
    wd[p] = d;
    cyc(1);
    go[p] = 1'b0;
    n = 0;
    while (dn[p] !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("ack", dn[p], 1'b1);
    r = got[p];
  endtask : op

  task automatic wr_ok(input int p, input logic [31:0] a, input logic [31:0] d);
    resp_t r;
    op(p, 1'b1, a, d, r);
    chk("wr_err", r.err, 1'b0);
  endtask : wr_ok

  // expected is {err, cache_hit, corrected, double_err, rdata}
  task automatic rchk(input string nm, input int p, input logic [31:0] a, input logic [35:0] exp);
    resp_t r;
    op(p, 1'b0, a, 32'h0, r);
    chk(nm, {r.err, r.cache_hit, r.corrected, r.double_err, r.rdata}, exp);
  endtask : rchk

  task automatic boot(input logic cl, input logic sp);
    int n;
    resetn = 1'b0;
    clamp = cl;
    split = sp;
    cyc(5);
    chk("rst_cores", core_rst, 2'b11);
    chk("rst_mode", mode_valid, 1'b0);
    resetn = 1'b1;
    n = 0;
    while (mode_valid !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("mode_valid", mode_valid, 1'b1);
    chk("mode_ls", mode_lockstep, !(sp && !cl));
    clamp = ~cl;
    split = ~sp;
    cyc(10);
    chk("mode_held", mode_lockstep, !(sp && !cl));
  endtask : boot

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      boot(i[1], i[0]);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_split();
    logic [31:0] win [4];
    boot(1'b0, 1'b1);
    wr_ok(0, LOC_BANK_A + 32'h4, 32'h1111_0001);
    wr_ok(0, LOC_BANK_B + 32'h4, 32'h2222_0002);
    rchk("c0_a", 0, LOC_BANK_A + 32'h4, {4'h0, 32'h1111_0001});
    rchk("g_c0a", 2, GBL_C0_A + 32'h4, {4'h0, 32'h1111_0001});
    rchk("g_c0b", 2, GBL_C0_B + 32'h4, {4'h0, 32'h2222_0002});
    wr_ok(1, LOC_BANK_A + 32'h8, 32'h3333_0003);
    wr_ok(1, LOC_BANK_B + 32'h8, 32'h4444_0004);
    rchk("g_c1a", 2, GBL_C1_A + 32'h8, {4'h0, 32'h3333_0003});
    rchk("g_c1b", 2, GBL_C1_B + 32'h8, {4'h0, 32'h4444_0004});
    win = '{GBL_C0_ICACHE, GBL_C0_DCACHE, GBL_C1_ICACHE, GBL_C1_DCACHE};
    foreach (win[i]) rchk("cache", 2, win[i], {4'h4, 32'h0});
    ppu_allow = 1'b0;
    rchk("g_deny", 2, GBL_C0_A + 32'h4, {4'h8, 32'h0});
    ppu_allow = 1'b1;
    rchk("c0_hole", 0, 32'h0001_0000, {4'h8, 32'h0});
    $display("test split done");
  endtask : t_split

  task automatic t_ecc();
    resp_t r;
    inj = 39'h00_0000_0100;
    wr_ok(0, LOC_BANK_A + 32'h20, 32'hA5A5_5A5A);
    inj = 39'h40_0000_0000;
    wr_ok(0, LOC_BANK_A + 32'h24, 32'h5A5A_A5A5);
    inj = 39'h00_0000_0300;
    wr_ok(0, LOC_BANK_A + 32'h28, 32'h0F0F_F0F0);
    inj = '0;
    rchk("ecc_data", 0, LOC_BANK_A + 32'h20, {4'h2, 32'hA5A5_5A5A});
    rchk("ecc_check", 0, LOC_BANK_A + 32'h24, {4'h2, 32'h5A5A_A5A5});
    op(0, 1'b0, LOC_BANK_A + 32'h28, 32'h0, r);
    chk("ecc_double", {r.corrected, r.double_err}, 2'b01);
    $display("test ecc done");
  endtask : t_ecc

  task automatic t_rst();
    rq1 = 1'b1;
    sig1 = 32'h0000_0001;
    cyc(2);
    chk("split_rst", core_rst, 2'b10);
    rq1 = 1'b0;
    cyc(3);
    chk("split_free", core_rst, 2'b00);
    chk("split_nofault", fault, 1'b0);
    sig1 = 32'h0;
    $display("test reset done");
  endtask : t_rst

  task automatic t_lock();
    boot(1'b1, 1'b0);
    wr_ok(0, LOC_BANK_A + 32'h10, 32'h6666_0006);
    wr_ok(0, 32'h0001_0010, 32'h5555_0005);
    rchk("ls_a_lo", 2, GBL_C0_A + 32'h10, {4'h0, 32'h6666_0006});
    rchk("ls_a_hi", 2, GBL_LS_A_HI + 32'h10, {4'h0, 32'h5555_0005});
    wr_ok(2, GBL_LS_B_HI + 32'h10, 32'h7777_0007);
    rchk("ls_b_hi", 0, 32'h0003_0010, {4'h0, 32'h7777_0007});
    wr_ok(0, LOC_BANK_B + 32'h10, 32'h8888_0008);
    rchk("ls_b_lo", 2, GBL_C0_B + 32'h10, {4'h0, 32'h8888_0008});
    rchk("ls_unmap", 2, GBL_C1_A, {4'h8, 32'h0});
    go[1] = 1'b1;
    wr[1] = 1'b0;
    ad[1] = LOC_BANK_A;
    cyc(1);
    go[1] = 1'b0;
    cyc(12);
    chk("c1_ignored", rq[1].valid, 1'b1);
    rq0 = 1'b1;
    cyc(2);
    chk("ls_rst", core_rst, 2'b11);
    rq0 = 1'b0;
    cyc(2);
    chk("ls_nofault", fault, 1'b0);
    sig1 = 32'h0000_0001;
    cyc(3);
    chk("ls_fault", fault, 1'b1);
    $display("test lockstep done");
  endtask : t_lock

  initial begin
    resetn = 1'b0;
    clamp = 1'b0;
    split = 1'b1;
    {rq0, rq1, sig0, sig1, inj} = '0;
    ppu_allow = 1'b1;
    go = '{3{1'b0}};
    wr = '{3{1'b0}};
    ad = '{3{32'h0}};
    wd = '{3{32'h0}};
    err_count = 0;
    checks = 0;
    cyc(1);
    t_modes();
    t_split();
    t_ecc();
    t_rst();
    t_lock();
    wrap_up();
  end

  // tests need about 300 cycles; allow ten times that
  initial begin
    #(3000 * 40);
    err_count++;
    wrap_up();
  end
endmodule : test_rpu_tcm_map
`default_nettype wire
